// file: rtl/pfi_ctrl.sv
// Purpose: Per-record countdown counter that injects pseudo faults
// Assumes: Register access strobes come from logic on ref_clk_i
`timescale 1ns/1ns
`default_nettype none
module pfi_ctrl (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic warm_rst_b_i,
  input wire logic [pfi_pkg::SEL_W-1:0] rec_sel_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [1:0] reg_idx_i,
  input wire logic [pfi_pkg::REG_W-1:0] reg_wdata_i,
  output logic [pfi_pkg::REG_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output pfi_pkg::pfi_inject_t inject_o
);
  pfi_pkg::pfi_ctl_t ctl_r [pfi_pkg::NUM_REC];
  pfi_pkg::pfi_ctl_t ctl_nxt [pfi_pkg::NUM_REC];
  logic [pfi_pkg::CNT_W-1:0] reload_r [pfi_pkg::NUM_REC];
  logic [pfi_pkg::CNT_W-1:0] reload_nxt [pfi_pkg::NUM_REC];
  logic [pfi_pkg::CNT_W-1:0] cnt_r [pfi_pkg::NUM_REC];
  logic [pfi_pkg::CNT_W-1:0] cnt_nxt [pfi_pkg::NUM_REC];
  pfi_pkg::pfi_cnt_state_t st_r [pfi_pkg::NUM_REC];
  pfi_pkg::pfi_cnt_state_t st_nxt [pfi_pkg::NUM_REC];
  logic [pfi_pkg::REG_W-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  pfi_pkg::pfi_inject_t inj_r, inj_nxt;

  function automatic logic [pfi_pkg::REG_W-1:0] pack_ctl(input pfi_pkg::pfi_ctl_t c);
    logic [pfi_pkg::REG_W-1:0] v;
    v = pfi_pkg::CTL_RESET;
    v[pfi_pkg::CTL_EN_BIT] = c.en;
    v[pfi_pkg::CTL_AUTO_BIT] = c.auto_reload;
    v[pfi_pkg::CTL_POISON_BIT] = c.poison;
    v[pfi_pkg::CTL_CRIT_BIT] = c.critical;
    v[pfi_pkg::CTL_CE_HI:pfi_pkg::CTL_CE_LO] = c.ce_sel;
    v[pfi_pkg::CTL_DEFER_BIT] = c.defer_en;
    v[pfi_pkg::CTL_UNCONT_BIT] = c.uncont_en;
    v[pfi_pkg::CTL_OVF_BIT] = c.ovf;
    return v;
  endfunction

  function automatic pfi_pkg::pfi_ctl_t unpack_ctl(input logic [pfi_pkg::REG_W-1:0] w);
    pfi_pkg::pfi_ctl_t c;
    c.en = w[pfi_pkg::CTL_EN_BIT];
    c.auto_reload = w[pfi_pkg::CTL_AUTO_BIT];
    c.poison = w[pfi_pkg::CTL_POISON_BIT];
    c.critical = w[pfi_pkg::CTL_CRIT_BIT];
    c.ce_sel = w[pfi_pkg::CTL_CE_HI:pfi_pkg::CTL_CE_LO];
    c.defer_en = w[pfi_pkg::CTL_DEFER_BIT];
    c.uncont_en = w[pfi_pkg::CTL_UNCONT_BIT];
    c.ovf = w[pfi_pkg::CTL_OVF_BIT];
    return c;
  endfunction

  // Register writes, counter and injection
  always_comb begin
    logic wr_ctl;
    logic wr_reload;
    logic fire;
    wr_ctl = 1'b0;
    wr_reload = 1'b0;
    fire = 1'b0;
    inj_nxt = '0;
    for (int i = 0; i < pfi_pkg::NUM_REC; i++) begin
      wr_ctl = reg_wr_i && (reg_idx_i == pfi_pkg::REG_CTL) &&
               (rec_sel_i == i[pfi_pkg::SEL_W-1:0]);
      wr_reload = reg_wr_i && (reg_idx_i == pfi_pkg::REG_RELOAD) &&
                  (rec_sel_i == i[pfi_pkg::SEL_W-1:0]);
      ctl_nxt[i] = wr_ctl ? unpack_ctl(reg_wdata_i) : ctl_r[i];
      reload_nxt[i] = wr_reload ? reg_wdata_i[pfi_pkg::CNT_W-1:0] : reload_r[i];
      cnt_nxt[i] = cnt_r[i];
      st_nxt[i] = st_r[i];
      fire = 1'b0;
      case (st_r[i])
        pfi_pkg::CNT_IDLE: begin
        end
        pfi_pkg::CNT_RUN: begin
          if (cnt_r[i] > 32'h0000_0001) begin
            cnt_nxt[i] = cnt_r[i] - 32'h0000_0001;
          end else begin
            fire = 1'b1;
            if (ctl_r[i].auto_reload) begin
              cnt_nxt[i] = reload_r[i];
            end else begin
              cnt_nxt[i] = '0;
              st_nxt[i] = pfi_pkg::CNT_IDLE;
            end
          end
        end
        default: st_nxt[i] = pfi_pkg::CNT_IDLE;
      endcase
      if (!ctl_r[i].en) begin
        fire = 1'b0;
        st_nxt[i] = pfi_pkg::CNT_IDLE;
      end
      if (wr_ctl && reg_wdata_i[pfi_pkg::CTL_EN_BIT]) begin
        cnt_nxt[i] = reload_r[i];
        st_nxt[i] = pfi_pkg::CNT_RUN;
      end else if (wr_ctl) begin
        st_nxt[i] = pfi_pkg::CNT_IDLE;
      end
      if (fire && !inj_nxt.valid) begin
        inj_nxt.valid = (ctl_r[i].ce_sel == pfi_pkg::CE_NONSPEC) ||
                        ctl_r[i].defer_en || ctl_r[i].uncont_en;
        inj_nxt.rec = i[pfi_pkg::SEL_W-1:0];
        inj_nxt.ce_code = (ctl_r[i].ce_sel == pfi_pkg::CE_NONSPEC) ?
                          pfi_pkg::CE_CODE_NONSPEC : 2'h0;
        inj_nxt.defer = ctl_r[i].defer_en;
        inj_nxt.uncont = ctl_r[i].uncont_en;
        inj_nxt.poison = ctl_r[i].poison;
        inj_nxt.critical = ctl_r[i].critical;
        inj_nxt.ovf = ctl_r[i].ovf;
      end
    end
  end

  // Read path: counter itself is never returned
  always_comb begin
    rvalid_nxt = reg_rd_i;
    rdata_nxt = '0;
    if (reg_rd_i) begin
      case (reg_idx_i)
        pfi_pkg::REG_CTL: rdata_nxt = pack_ctl(ctl_r[rec_sel_i]);
        pfi_pkg::REG_RELOAD: rdata_nxt = {32'h0000_0000, reload_r[rec_sel_i]};
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    for (int i = 0; i < pfi_pkg::NUM_REC; i++) begin
      reload_r[i] <= reload_nxt[i];
      if (!rst_b_i) begin
        ctl_r[i] <= unpack_ctl(pfi_pkg::CTL_RESET);
        cnt_r[i] <= '0;
        st_r[i] <= pfi_pkg::CNT_IDLE;
      end else if (!warm_rst_b_i) begin
        ctl_r[i] <= ctl_r[i];
        cnt_r[i] <= cnt_r[i];
        st_r[i] <= st_r[i];
      end else begin
        ctl_r[i] <= ctl_nxt[i];
        cnt_r[i] <= cnt_nxt[i];
        st_r[i] <= st_nxt[i];
      end
    end
    if (!rst_b_i || !warm_rst_b_i) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      inj_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      inj_r <= inj_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;
  assign inject_o = inj_r;
endmodule
`default_nettype wire

// file: rtl/pfi_pkg.sv
// Purpose: Shared constants and types for the pseudo fault injection control
// Assumes: 64-bit system register access port, one access per cycle
// Notes: Bit positions follow the control register layout
package pfi_pkg;
  localparam int unsigned REG_W = 64;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned NUM_REC = 2;
  localparam int unsigned SEL_W = 1;
  localparam int unsigned CTL_EN_BIT = 31;
  localparam int unsigned CTL_AUTO_BIT = 30;
  localparam int unsigned CTL_RES1_BIT = 12;
  localparam int unsigned CTL_POISON_BIT = 10;
  localparam int unsigned CTL_CRIT_BIT = 8;
  localparam int unsigned CTL_CE_HI = 7;
  localparam int unsigned CTL_CE_LO = 6;
  localparam int unsigned CTL_DEFER_BIT = 5;
  localparam int unsigned CTL_UNCONT_BIT = 1;
  localparam int unsigned CTL_OVF_BIT = 0;
  localparam logic [REG_W-1:0] CTL_RESET = 64'h0000_0000_0000_1000;
  localparam logic [1:0] CE_OFF = 2'h0;
  localparam logic [1:0] CE_NONSPEC = 2'h1;
  localparam logic [1:0] CE_CODE_NONSPEC = 2'h2;
  localparam logic [1:0] REG_CTL = 2'h0;
  localparam logic [1:0] REG_RELOAD = 2'h1;

  typedef enum logic [1:0] {
    CNT_IDLE = 2'b00,
    CNT_RUN = 2'b01
  } pfi_cnt_state_t;

  typedef struct packed {
    logic       en;
    logic       auto_reload;
    logic       poison;
    logic       critical;
    logic [1:0] ce_sel;
    logic       defer_en;
    logic       uncont_en;
    logic       ovf;
  } pfi_ctl_t;

  typedef struct packed {
    logic       valid;
    logic [SEL_W-1:0] rec;
    logic [1:0] ce_code;
    logic       defer;
    logic       uncont;
    logic       poison;
    logic       critical;
    logic       ovf;
  } pfi_inject_t;
endpackage

// file: tb/pfi_ctrl_assertions.sv
// Purpose: Port assertions for the fault injection control
// Assumes: One clock, resets active low
// Notes: Attached by bind
`timescale 1ns/1ns
`default_nettype none
module pfi_ctrl_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic warm_rst_b_i,
  input wire logic [pfi_pkg::SEL_W-1:0] rec_sel_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [1:0] reg_idx_i,
  input wire logic [pfi_pkg::REG_W-1:0] reg_wdata_i,
  input wire logic [pfi_pkg::REG_W-1:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire pfi_pkg::pfi_inject_t inject_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_read_answer: assert property (reg_rd_i && warm_rst_b_i ##1 warm_rst_b_i |-> reg_rvalid_o)
    else $error("read not answered");
  a_answer_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("answer without read");
  a_idle_data: assert property (!reg_rvalid_o |-> reg_rdata_o == '0)
    else $error("read data not idle");
  a_reload_upper: assert property (reg_rd_i && reg_idx_i == pfi_pkg::REG_RELOAD |=> reg_rdata_o[63:32] == 32'h0)
    else $error("countdown upper half set");
  a_unmapped_zero: assert property (reg_rd_i && reg_idx_i > 2'h1 |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  a_ce_code: assert property (inject_o.valid |-> inject_o.ce_code inside {2'h0, 2'h2})
    else $error("bad corrected code");
  a_kind_needed: assert property (inject_o.valid |-> inject_o.ce_code != 2'h0 || inject_o.defer || inject_o.uncont)
    else $error("injection without kind");
  a_warm_quiet: assert property (!warm_rst_b_i |=> !inject_o.valid && !reg_rvalid_o)
    else $error("output during warm reset");
endmodule
bind pfi_ctrl pfi_ctrl_assertions u_chk (.ref_clk_i, .rst_b_i, .warm_rst_b_i, .rec_sel_i,
  .reg_wr_i, .reg_rd_i, .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .inject_o);
`default_nettype wire

// file: tb/pfi_ctrl_tb.sv
// Purpose: Self-checking bench for the fault injection control
// Assumes: Inputs change on the falling edge
// Notes: Short countdowns keep the run brief
`timescale 1ns/1ns
`default_nettype none
module pfi_ctrl_tb;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic warm_rst_b_i = 1'b1;
  logic [pfi_pkg::SEL_W-1:0] rec_sel_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [1:0] reg_idx_i = 2'h0;
  logic [63:0] reg_wdata_i = '0;
  logic [63:0] reg_rdata_o;
  logic reg_rvalid_o;
  pfi_pkg::pfi_inject_t inject_o;
  int mismatches = 0;
  int n_checks = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  pfi_ctrl DUT (.ref_clk_i, .rst_b_i, .warm_rst_b_i, .rec_sel_i, .reg_wr_i, .reg_rd_i,
    .reg_idx_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .inject_o);
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cmp(string what, logic [63:0] exp, logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [1:0] idx, logic [63:0] d);
    @(negedge ref_clk_i);
    reg_wr_i = 1'b1;
    reg_idx_i = idx;
    reg_wdata_i = d;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(logic [1:0] idx, logic [63:0] exp);
    int i;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b1;
    reg_idx_i = idx;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    for (i = 0; i < 3 && reg_rvalid_o !== 1'b1; i++) @(negedge ref_clk_i);
    if (i == 3) begin
      mismatches++;
      report_and_stop();
    end else begin
      cmp("read data", exp, reg_rdata_o);
    end
  endtask
  task automatic fire(int n, pfi_pkg::pfi_inject_t exp);
    for (int i = 1; i <= n; i++) begin
      @(negedge ref_clk_i);
      cmp("inject valid", (i == n) ? exp.valid : 1'b0, inject_o.valid);
      if (i == n && exp.valid) cmp("inject", exp, inject_o);
    end
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    rd(pfi_pkg::REG_CTL, 64'h1000);
    rd(2'h2, 64'h0);
    wr(pfi_pkg::REG_RELOAD, 64'h5);
    rd(pfi_pkg::REG_RELOAD, 64'h5);
    wr(pfi_pkg::REG_CTL, 64'h8000_0563);
    fire(5, 9'h15F);
    fire(12, 9'h0);
    rec_sel_i = 1'b1;
    wr(pfi_pkg::REG_RELOAD, 64'h4);
    wr(pfi_pkg::REG_CTL, 64'hC000_0020);
    fire(4, 9'h190);
    fire(4, 9'h190);
    wr(pfi_pkg::REG_CTL, 64'h0);
    fire(12, 9'h0);
    rec_sel_i = 1'b0;
    rd(pfi_pkg::REG_CTL, 64'h8000_1563);
    rec_sel_i = 1'b1;
    wr(pfi_pkg::REG_CTL, 64'h0000_0563);
    warm_rst_b_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    warm_rst_b_i = 1'b1;
    rd(pfi_pkg::REG_CTL, 64'h1563);
    rst_b_i = 1'b0;
    repeat (2) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    rd(pfi_pkg::REG_CTL, 64'h1000);
    rd(pfi_pkg::REG_RELOAD, 64'h4);
    report_and_stop();
  end
endmodule
`default_nettype wire
